// ==== design/pbss_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module pbss_top
#(
  parameter int unsigned ADDR_W = pbss_pkg::ADDR_W
)
(
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         arst_n_i,
  // address and strobes
  input  wire logic [ADDR_W-1:0]            addr_i,
  input  wire logic                         processor_addr_strobe_n_i,
  input  wire logic                         controller_addr_strobe_n_i,
  input  wire logic                         burst_advance_n_i,
  // selects
  input  wire logic                         master_select_n_i,
  input  wire logic                         secondary_select_high_i,
  input  wire logic                         secondary_select_low_n_i,
  // write controls
  input  wire logic                         all_bytes_write_n_i,
  input  wire logic                         byte_write_gate_n_i,
  input  wire logic [pbss_pkg::LANES-1:0]   lane_write_selects_n_i,
  // asynchronous and static pins
  input  wire logic                         output_enable_n_i,
  input  wire logic                         burst_order_select_i,
  input  wire logic                         sleep_request_i,
  // shared data bus
  input  wire logic [pbss_pkg::DATA_W-1:0]  dq_i,
  output logic      [pbss_pkg::DATA_W-1:0]  dq_o,
  output logic                              dq_oe_n_o,
  // write path status
  output logic                              write_ready_o
);

  localparam int unsigned DW   = pbss_pkg::DATA_W;
  localparam int unsigned LW   = pbss_pkg::LANE_W;
  localparam int unsigned NL   = pbss_pkg::LANES;
  localparam int unsigned WB_W = ADDR_W + NL + DW;

  typedef struct packed {
    logic [pbss_pkg::SYNC_N-1:0] zz_sync;
    logic [pbss_pkg::SYNC_N-1:0] order_sync;
    logic                        zz;
    logic                        interleave;
    logic                        active;
    logic [ADDR_W-1:0]           base;
    logic [pbss_pkg::CNT_W-1:0]  cnt;
    logic [ADDR_W-1:0]           acc_addr;
    logic                        rd_pend;
    logic                        drv;
    logic [DW-1:0]               dq_out;
  } pbss_state_t;

  pbss_state_t        st_r;
  pbss_state_t        st_nxt;

  // array storage, no reset: contents survive sleep
  logic [DW-1:0]      mem [0:(2**ADDR_W)-1];
  logic [DW-1:0]      mem_rdata;

  logic               sel_ok;
  logic               proc_go;
  logic               ctrl_go;
  logic               new_cyc;
  logic [NL-1:0]      lane_wr;
  logic [NL-1:0]      wr_mask;
  logic               wr_cmd;
  logic               lane_low;
  logic               acc;
  logic               is_wr;
  logic [1:0]         low_addr;
  logic [ADDR_W-1:0]  acc_addr;
  logic               start_cyc;
  logic               step_cyc;
  logic [ADDR_W-1:0]  base_nxt;
  logic [pbss_pkg::CNT_W-1:0] cnt_nxt;

  logic               wb_in_valid;
  logic               wb_in_ready;
  logic [WB_W-1:0]    wb_in_data;
  logic               wb_out_valid;
  logic               wb_out_ready;
  logic [WB_W-1:0]    wb_out_data;
  logic [ADDR_W-1:0]  wq_addr;
  logic [NL-1:0]      wq_mask;
  logic [DW-1:0]      wq_data;

  // decoding of the sampled control pins
  assign sel_ok   = secondary_select_high_i
                  & ~secondary_select_low_n_i;
  assign proc_go  = ~processor_addr_strobe_n_i
                  & ~master_select_n_i;
  assign ctrl_go  = ~controller_addr_strobe_n_i & ~proc_go;
  assign new_cyc  = proc_go | ctrl_go;
  assign lane_wr  = byte_write_gate_n_i ? '0
                  : ~lane_write_selects_n_i;
  assign wr_mask  = all_bytes_write_n_i ? lane_wr : '1;
  assign wr_cmd   = |wr_mask;
  assign lane_low = wr_cmd & ~proc_go;

  // next burst base and count, kept apart from the state copy so that
  // the sequencer output does not loop back through the whole struct
  assign start_cyc = ~st_r.zz & new_cyc;
  assign step_cyc  = ~st_r.zz & ~new_cyc & st_r.active & ~burst_advance_n_i;
  assign base_nxt  = start_cyc ? addr_i : st_r.base;
  assign cnt_nxt   = start_cyc ? pbss_pkg::CNT_RST
                   : step_cyc ? st_r.cnt + 2'h1 : st_r.cnt;

  pbss_burst_seq u_burst_seq
  (
    .start_i      (base_nxt[1:0]),
    .count_i      (cnt_nxt),
    .interleave_i (st_r.interleave),
    .low_addr_o   (low_addr)
  );

  assign acc_addr  = {base_nxt[ADDR_W-1:2], low_addr};
  assign mem_rdata = mem[st_r.acc_addr];

  always_comb
  begin
    st_nxt = st_r;
    acc    = 1'b0;
    is_wr  = 1'b0;

    // three-stage synchronisers; change taken when stages 2 and 3 agree
    st_nxt.zz_sync    = {st_r.zz_sync[1:0], sleep_request_i};
    st_nxt.order_sync = {st_r.order_sync[1:0], burst_order_select_i};
    if (st_r.zz_sync[1] == st_r.zz_sync[2])
      st_nxt.zz = st_r.zz_sync[2];
    if (st_r.order_sync[1] == st_r.order_sync[2])
      st_nxt.interleave = st_r.order_sync[2];

    if (!st_r.zz)
    begin
      if (new_cyc)
      begin
        st_nxt.active = sel_ok;
        st_nxt.base   = base_nxt;
        st_nxt.cnt    = cnt_nxt;
        acc           = sel_ok;
        is_wr         = ctrl_go & wr_cmd & sel_ok;
      end
      else if (st_r.active)
      begin
        st_nxt.cnt = cnt_nxt;
        acc   = 1'b1;
        is_wr = wr_cmd;
      end
    end

    if (acc)
      st_nxt.acc_addr = acc_addr;
    st_nxt.rd_pend = acc & ~is_wr;
    st_nxt.drv     = st_r.rd_pend & ~lane_low & ~st_r.zz;
    if (st_r.rd_pend)
      st_nxt.dq_out = mem_rdata;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r            <= '0;
      st_r.zz_sync    <= pbss_pkg::SYNC_RST;
      st_r.order_sync <= pbss_pkg::ORDER_RST;
      st_r.interleave <= 1'b1;
      st_r.cnt        <= pbss_pkg::CNT_RST;
    end
    else
      st_r <= st_nxt;
  end

  // captured write words queue in front of the array
  assign wb_in_valid = is_wr;
  assign wb_in_data  = {acc_addr, wr_mask, dq_i};
  assign wb_out_ready = ~st_r.zz;
  assign {wq_addr, wq_mask, wq_data} = wb_out_data;
  assign write_ready_o = wb_in_ready;

  pbss_wbuf
  #(
    .WIDTH (WB_W)
  )
  u_wbuf
  (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (wb_in_valid),
    .in_ready_o  (wb_in_ready),
    .in_data_i   (wb_in_data),
    .out_valid_o (wb_out_valid),
    .out_ready_i (wb_out_ready),
    .out_data_o  (wb_out_data)
  );

  always_ff @(posedge clk_i)
  begin
    if (wb_out_valid && wb_out_ready)
    begin
      for (int i = 0; i < NL; i++)
      begin
        if (wq_mask[i])
          mem[wq_addr][i*LW +: LW] <= wq_data[i*LW +: LW];
      end
    end
  end

  // data bus: output enable gates the driver without a clock
  assign dq_o      = st_r.dq_out;
  assign dq_oe_n_o = ~(st_r.drv & ~output_enable_n_i & ~st_r.zz);

  a_read_latency: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    st_r.rd_pend |=> (st_r.dq_out == $past(mem_rdata)))
    else $error("read word not in output register one edge later");

  a_single_deselect: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !st_r.rd_pend |=> !st_r.drv)
    else $error("drivers still on one cycle after deselect");

  a_lane_write_off: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (lane_low && !st_r.zz) |=> dq_oe_n_o)
    else $error("drivers on after a lane write was sampled low");

  a_proc_start_read: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (proc_go && sel_ok && !st_r.zz) |=>
      (st_r.rd_pend && st_r.cnt == 2'h0
       && st_r.base == $past(addr_i)))
    else $error("processor strobe did not start a read");

  a_advance_step: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (!new_cyc && st_r.active && !burst_advance_n_i && !st_r.zz) |=>
      (st_r.cnt == $past(st_r.cnt) + 2'h1))
    else $error("burst address did not step on advance");

  a_global_write: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (wb_in_valid && !all_bytes_write_n_i) |->
      (wb_in_data[DW +: NL] == '1))
    else $error("global write did not cover all lanes");

  a_ctrl_write: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (ctrl_go && sel_ok && wr_cmd && !st_r.zz) |->
      (wb_in_valid && wb_in_data[DW-1:0] == dq_i))
    else $error("controller strobe write not taken on its edge");

  a_sleep_float: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    st_r.zz |=> (dq_oe_n_o && !st_r.rd_pend))
    else $error("outputs driven or read started while asleep");

  a_drive_gate: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !dq_oe_n_o |-> (!output_enable_n_i && st_r.drv))
    else $error("data bus driven without read and enable");

  a_order_xor: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (acc && !new_cyc && st_r.interleave) |=>
      (st_r.acc_addr[1:0] == (st_r.base[1:0] ^ st_r.cnt)))
    else $error("interleaved burst address out of order");

  a_order_linear: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (acc && !new_cyc && !st_r.interleave) |=>
      (st_r.acc_addr[1:0] == 2'(st_r.base[1:0] + st_r.cnt)))
    else $error("linear burst address out of order");

  a_upper_addr_hold: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    acc |=> (st_r.acc_addr[ADDR_W-1:2] == st_r.base[ADDR_W-1:2]))
    else $error("burst left its four-word block");

  a_proc_no_write: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    proc_go |-> !wb_in_valid)
    else $error("write taken on a processor strobe edge");

  a_hold_no_adv: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (!new_cyc && st_r.active && burst_advance_n_i && !st_r.zz) |=>
      $stable(st_r.cnt))
    else $error("burst address moved without advance");

  a_lane_mask: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (wb_in_valid && all_bytes_write_n_i) |->
      (wb_in_data[DW +: NL] == ~lane_write_selects_n_i))
    else $error("lane write mask differs from lane selects");

  a_read_no_write: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (all_bytes_write_n_i && byte_write_gate_n_i) |-> !wb_in_valid)
    else $error("write taken with no write input active");

  a_sleep_no_write: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    st_r.zz |-> !wb_in_valid)
    else $error("write taken while asleep");

  a_deselect_idle: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (new_cyc && !sel_ok && !st_r.zz) |=>
      (!st_r.active && !st_r.rd_pend))
    else $error("access started while deselected");

  a_drive_follows: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_r.rd_pend && !lane_low && !st_r.zz) |=> st_r.drv)
    else $error("read word not driven one cycle after access");

endmodule // pbss_top

`default_nettype wire

// ==== design/pbss_pkg.sv ====
`default_nettype none

package pbss_pkg;

  // array shape: 2,097,152 words of two 9-bit lanes
  localparam int unsigned DATA_W  = 18;
  localparam int unsigned ADDR_W  = 21;
  localparam int unsigned LANES   = 2;
  localparam int unsigned LANE_W  = 9;

  // burst counter acts on the two low address bits
  localparam int unsigned CNT_W   = 2;
  localparam logic [1:0]  CNT_RST = 2'h0;

  // pin synchroniser depth and reset values of the async pins
  localparam int unsigned SYNC_N   = 3;
  localparam logic [2:0]  SYNC_RST = 3'h0;
  localparam logic [2:0]  ORDER_RST = 3'h7;

  // write buffer depth
  localparam int unsigned WBUF_DEPTH = 2;

endpackage

`default_nettype wire

// ==== design/pbss_burst_seq.sv ====
`timescale 1ns/100ps
`default_nettype none

module pbss_burst_seq
(
  // burst start, step count and order
  input  wire logic [1:0] start_i,
  input  wire logic [1:0] count_i,
  input  wire logic       interleave_i,
  // low address bits of the current access
  output logic      [1:0] low_addr_o
);

  always_comb
  begin
    if (interleave_i)
      low_addr_o = start_i ^ count_i;
    else
      low_addr_o = start_i + count_i;
  end

endmodule // pbss_burst_seq

`default_nettype wire

// ==== design/pbss_wbuf.sv ====
`timescale 1ns/100ps
`default_nettype none

module pbss_wbuf
#(
  parameter int unsigned WIDTH = 41
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] ent;
    logic [1:0]            count;
  } pbss_wbuf_state_t;

  pbss_wbuf_state_t st_r;
  pbss_wbuf_state_t st_nxt;
  logic             push;
  logic             pop;

  assign in_ready_o  = (st_r.count != 2'h2);
  assign out_valid_o = (st_r.count != 2'h0);
  assign out_data_o  = st_r.ent[0];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb
  begin
    st_nxt = st_r;
    if (pop)
    begin
      st_nxt.ent[0] = st_r.ent[1];
      st_nxt.count  = st_nxt.count - 2'h1;
    end
    if (push)
    begin
      st_nxt.ent[st_nxt.count[0]] = in_data_i;
      st_nxt.count                = st_nxt.count + 2'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  a_buf_bound: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (push && !pop) |=> (st_r.count == $past(st_r.count) + 2'h1))
    else $error("write buffer lost a captured word");

endmodule // pbss_wbuf

`default_nettype wire

// ==== sim/pbss_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module pbss_host_model
(
  // clock
  input  wire logic        clk_i,
  // pins toward the memory
  output logic [5:0]       addr_o,
  output logic             ps_n_o,
  output logic             cs_n_o,
  output logic             adv_n_o,
  output logic             msel_n_o,
  output logic             ssh_o,
  output logic             ssl_n_o,
  output logic             gwe_n_o,
  output logic             gate_n_o,
  output logic [1:0]       lane_n_o,
  output logic             oe_n_o,
  output logic             order_o,
  output logic             sleep_o,
  // data bus as both parties see it
  input  wire logic [17:0] rd_i,
  input  wire logic        rd_oe_n_i,
  output logic [17:0]      bus_o
);
  logic        host_en;
  logic        oe_block;
  logic [17:0] host_d;
  logic [17:0] pat;

  // a released bus shows a pattern that changes every cycle
  always @(posedge clk_i)
    pat <= {pat[16:0], ~pat[17]};
  assign bus_o = !rd_oe_n_i ? rd_i : host_en ? host_d : pat;

  task automatic put(input logic ps, cs, burst_advance, all_bytes_write, gate,
                     input logic [1:0] ln, input logic [5:0] a,
                     input logic [17:0] d, input logic [1:0] sel);
    host_en = !all_bytes_write || ln != 2'h3;
    host_d = d;
    oe_n_o = host_en || oe_block;
    ps_n_o = ps;
    cs_n_o = cs;
    adv_n_o = burst_advance;
    gwe_n_o = all_bytes_write;
    gate_n_o = gate;
    lane_n_o = ln;
    addr_o = a;
    msel_n_o = sel == 2'h3;
    ssh_o = sel != 2'h1;
    ssl_n_o = sel == 2'h2;
  endtask

  task automatic cyc(input logic ps, cs, burst_advance, all_bytes_write, gate,
                     input logic [1:0] ln, input logic [5:0] a,
                     input logic [17:0] d, input logic [1:0] sel);
    put(ps, cs, burst_advance, all_bytes_write, gate, ln, a, d, sel);
    @(posedge clk_i);
    #1;
  endtask

  task automatic idle();
    cyc(1, 1, 1, 1, 1, 2'h3, 6'h00, 18'h00000, 2'h0);
  endtask

  task automatic snooze(input logic s);
    idle();
    sleep_o = s;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  task automatic burst_order(input logic o);
    order_o = o;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  initial
  begin
    oe_block = 1'b0;
    order_o = 1'b1;
    sleep_o = 1'b0;
    pat = 18'h00000;
    put(1, 1, 1, 1, 1, 2'h3, 6'h00, 18'h00000, 2'h0);
  end
endmodule // pbss_host_model

`default_nettype wire

// ==== sim/test_pipelined_burst_sync_sram.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_pipelined_burst_sync_sram;
  logic        clk_i;
  logic        arst_n_i;
  logic        ps_n, cs_n, adv_n, msel_n, ssh, ssl_n, gwe_n, gate_n;
  logic        oe_n, order, sleep, dq_oe_n, wr_rdy;
  logic [1:0]  lane_n;
  logic [5:0]  addr;
  logic [17:0] bus, dq_o;
  logic [17:0] mem [64];
  int          errors;
  int          checks_done;

  pbss_top #(.ADDR_W(6)) dut_u
  (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr),
    .processor_addr_strobe_n_i(ps_n),
    .controller_addr_strobe_n_i(cs_n),
    .burst_advance_n_i(adv_n), .master_select_n_i(msel_n),
    .secondary_select_high_i(ssh), .secondary_select_low_n_i(ssl_n),
    .all_bytes_write_n_i(gwe_n), .byte_write_gate_n_i(gate_n),
    .lane_write_selects_n_i(lane_n), .output_enable_n_i(oe_n),
    .burst_order_select_i(order), .sleep_request_i(sleep),
    .dq_i(bus), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n),
    .write_ready_o(wr_rdy)
  );

  pbss_host_model u_host
  (
    .clk_i(clk_i), .addr_o(addr), .ps_n_o(ps_n), .cs_n_o(cs_n),
    .adv_n_o(adv_n), .msel_n_o(msel_n), .ssh_o(ssh), .ssl_n_o(ssl_n),
    .gwe_n_o(gwe_n), .gate_n_o(gate_n), .lane_n_o(lane_n),
    .oe_n_o(oe_n), .order_o(order), .sleep_o(sleep), .rd_i(dq_o),
    .rd_oe_n_i(dq_oe_n), .bus_o(bus)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial
  begin
    #50000;
    errors++;
    results();
  end

  task automatic results();
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // single access opened with the controller strobe
  task automatic wr(input logic [5:0] a, input logic [17:0] d,
                    input logic gw, gt, input logic [1:0] ln);
    u_host.cyc(1, 0, 1, gw, gt, ln, a, d, 2'h0);
    if (!gw || (!gt && !ln[0]))
      mem[a][8:0] = d[8:0];
    if (!gw || (!gt && !ln[1]))
      mem[a][17:9] = d[17:9];
    u_host.idle();
    chk(18'(wr_rdy), 18'h1, "write buffer refused");
  endtask

  task automatic rd(input logic [5:0] a, input int n, input logic il);
    logic [1:0] lo;
    u_host.cyc(0, 1, 0, 1, 1, 2'h3, a, 18'h0, 2'h0);
    for (int k = 0; k < n; k++)
    begin
      u_host.cyc(1, 1, k == n - 1, 1, 1, 2'h3, a, 18'h0, 2'h0);
      lo = il ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
      chk(bus, mem[{a[5:2], lo}], "read data");
      chk(18'(dq_oe_n), 18'h0, "read not driven");
    end
  endtask

  task automatic desel(input logic [1:0] sel);
    u_host.cyc(1, 0, 1, 1, 1, 2'h3, 6'h00, 18'h0, sel);
    chk(18'(dq_oe_n), 18'h0, "drive dropped early");
    u_host.idle();
    chk(18'(dq_oe_n), 18'h1, "drive held after deselect");
  endtask

  initial
  begin
    errors = 0;
    checks_done = 0;
    arst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    chk(18'(dq_oe_n), 18'h1, "driving in reset");
    arst_n_i = 1'b1;
    for (int i = 0; i < 16; i++)
      wr(6'(i), 18'h2a5a0 ^ 18'(i * 1057), 1'b0, 1'b1, 2'(i));
    rd(6'h01, 5, 1'b1);
    desel(2'h1);
    u_host.burst_order(1'b0);
    rd(6'h05, 5, 1'b0);
    desel(2'h2);
    u_host.cyc(0, 1, 1, 1, 1, 2'h3, 6'h02, 18'h0, 2'h3);
    u_host.idle();
    chk(18'(dq_oe_n), 18'h1, "blocked start drove");
    u_host.cyc(1, 0, 1, 1, 1, 2'h3, 6'h02, 18'h0, 2'h3);
    u_host.idle();
    chk(bus, mem[2], "controller start read");
    u_host.cyc(0, 0, 1, 0, 0, 2'h0, 6'h03, 18'h3ffff, 2'h0);
    u_host.idle();
    rd(6'h03, 1, 1'b0);
    wr(6'h04, 18'h15555, 1'b1, 1'b0, 2'h2);
    wr(6'h04, 18'h0aaaa, 1'b1, 1'b1, 2'h0);
    wr(6'h04, 18'h3c3c3, 1'b1, 1'b0, 2'h1);
    rd(6'h04, 1, 1'b0);
    u_host.cyc(1, 0, 1, 0, 1, 2'h3, 6'h09, 18'h11111, 2'h0);
    mem[9] = 18'h11111;
    for (int k = 1; k < 4; k++)
    begin
      u_host.cyc(1, 1, 0, 1, 0, 2'h0, 6'h09, 18'(k * 20560), 2'h0);
      mem[{4'h2, 2'(k + 1)}] = 18'(k * 20560);
      chk(18'(wr_rdy), 18'h1, "write buffer refused");
    end
    u_host.idle();
    rd(6'h09, 4, 1'b0);
    u_host.oe_block = 1'b1;
    u_host.cyc(0, 1, 1, 1, 1, 2'h3, 6'h00, 18'h0, 2'h0);
    u_host.idle();
    chk(18'(dq_oe_n), 18'h1, "driven with enable off");
    u_host.oe_block = 1'b0;
    rd(6'h00, 1, 1'b0);
    u_host.snooze(1'b1);
    chk(18'(dq_oe_n), 18'h1, "driven asleep");
    u_host.cyc(1, 0, 1, 0, 1, 2'h3, 6'h00, 18'h3ffff, 2'h0);
    u_host.snooze(1'b0);
    rd(6'h00, 1, 1'b0);
    results();
  end
endmodule // test_pipelined_burst_sync_sram

`default_nettype wire
